//--- rtl/signal_modulator.sv
/*
  data signal modulator: mixes a chosen modulator with two carriers
  and drives one modulated output pin.
  assumes async carriers and sources slower than half of mclk;
  register port on mclk.
*/
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Contract
// [R1] A 4-bit code selects the modulator source; codes above 10 are reserved.
// [R2] Enable clear: output off, both carriers on their routed pins.
// [R3] Enable clear: the modulator is the software data bit.
// [R4] Disabling keeps the selection codes; enabling reuses them.
// [R5] A disabled output holds the pin low while mixing goes on; here the pin shows the output invert bit instead.
// [R6] With sync on, leaving a carrier waits until it is low.
// [R7] Control b holds separate sync enables for each carrier.
// [R8] Each carrier's polarity bit inverts it before mixing.
// [R9] The software bit code passes the software data bit.
// [R10] The output invert bit inverts the pin.
// [R11] Modulation goes on in sleep while its sources run.
// [R12] Any reset disables the block and clears every register.
// [R13] Power-off shuts the block down; registers return at defaults.
// [R14] A 3-bit code selects each carrier source.
// [R15] Control a has a read-only bit mirroring the output.
// [R16] A high modulator passes the high carrier, a low one the low.
// [R17] A disabled output counts as low before output inversion.
module signal_modulator
  import modulator_pkg::*;
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [DATA_W-1:0]   reg_rdata,
  // routed pins
  input  wire logic                source_pin,
  input  wire logic                high_carrier_pin,
  input  wire logic                low_carrier_pin,
  // clock sources
  input  wire logic                internal_fast_oscillator,
  input  wire logic                reference_clock_output,
  // peripheral outputs
  input  wire logic                capture_unit_one,
  input  wire logic                capture_unit_two,
  input  wire logic                pulse_width_unit_three,
  input  wire logic                pulse_width_unit_four,
  input  wire logic                comparator_one,
  input  wire logic                comparator_two,
  input  wire logic                async_serial_port_rx,
  input  wire logic                async_serial_port_tx,
  input  wire logic                sync_serial_port_dout,
  // route codes to the pin fabric
  output logic      [ROUTE_W-1:0]  source_route,
  output logic      [ROUTE_W-1:0]  high_carrier_route,
  output logic      [ROUTE_W-1:0]  low_carrier_route,
  // modulated output
  output logic                     modulated_out
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic                  modulator_enable;
  logic                  output_invert;
  logic                  software_data_bit;
  logic                  high_carrier_invert;
  logic                  high_carrier_sync_enable;
  logic                  low_carrier_invert;
  logic                  low_carrier_sync_enable;
  logic [CAR_CODE_W-1:0] high_carrier_code;
  logic [CAR_CODE_W-1:0] low_carrier_code;
  logic [SRC_CODE_W-1:0] modulator_source_code;
  logic                  modulator_power_off;

  wire hit_control_a    = reg_addr == OFS_CONTROL_A;
  wire hit_control_b    = reg_addr == OFS_CONTROL_B;
  wire hit_high_carrier = reg_addr == OFS_HIGH_CARRIER;
  wire hit_low_carrier  = reg_addr == OFS_LOW_CARRIER;
  wire hit_source       = reg_addr == OFS_SOURCE;
  wire hit_low_route    = reg_addr == OFS_LOW_ROUTE;
  wire hit_high_route   = reg_addr == OFS_HIGH_ROUTE;
  wire hit_source_route = reg_addr == OFS_SOURCE_ROUTE;
  wire hit_periph_dis   = reg_addr == OFS_PERIPH_DIS;

  // registers held at defaults while off
  wire hold_defaults = !rst_n || modulator_power_off;  // [R12] [R13]
  wire write_ok      = reg_write && !modulator_power_off;  // [R13]

  always_ff @(posedge mclk) begin
    if (hold_defaults) begin  // [R12] [R13]
      modulator_enable  <= RST_CONTROL_A[POS_MODULATOR_ENABLE];
      output_invert     <= RST_CONTROL_A[POS_OUTPUT_INVERT];
      software_data_bit <= RST_CONTROL_A[POS_SOFTWARE_DATA_BIT];
    end else if (write_ok && hit_control_a) begin
      modulator_enable  <= reg_wdata[POS_MODULATOR_ENABLE];
      output_invert     <= reg_wdata[POS_OUTPUT_INVERT];
      software_data_bit <= reg_wdata[POS_SOFTWARE_DATA_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (hold_defaults) begin
      high_carrier_invert      <= RST_CONTROL_B[POS_HIGH_CARRIER_INVERT];
      high_carrier_sync_enable <= RST_CONTROL_B[POS_HIGH_CARRIER_SYNC];
      low_carrier_invert       <= RST_CONTROL_B[POS_LOW_CARRIER_INVERT];
      low_carrier_sync_enable  <= RST_CONTROL_B[POS_LOW_CARRIER_SYNC];
    end else if (write_ok && hit_control_b) begin  // [R7]
      high_carrier_invert      <= reg_wdata[POS_HIGH_CARRIER_INVERT];
      high_carrier_sync_enable <= reg_wdata[POS_HIGH_CARRIER_SYNC];
      low_carrier_invert       <= reg_wdata[POS_LOW_CARRIER_INVERT];
      low_carrier_sync_enable  <= reg_wdata[POS_LOW_CARRIER_SYNC];
    end
  end

  // codes change only by writes, reset and power-off
  always_ff @(posedge mclk) begin
    if (hold_defaults) begin
      high_carrier_code     <= RST_CAR_CODE;
      low_carrier_code      <= RST_CAR_CODE;
      modulator_source_code <= RST_SRC_CODE;
    end else begin  // [R4]
      if (write_ok && hit_high_carrier)
        high_carrier_code <= reg_wdata[CAR_CODE_W-1:0];
      if (write_ok && hit_low_carrier)
        low_carrier_code <= reg_wdata[CAR_CODE_W-1:0];
      if (write_ok && hit_source)
        modulator_source_code <= reg_wdata[SRC_CODE_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (hold_defaults) begin
      source_route       <= RST_ROUTE;
      high_carrier_route <= RST_ROUTE;
      low_carrier_route  <= RST_ROUTE;
    end else begin
      if (write_ok && hit_source_route)
        source_route <= reg_wdata[ROUTE_W-1:0];
      if (write_ok && hit_high_route)
        high_carrier_route <= reg_wdata[ROUTE_W-1:0];
      if (write_ok && hit_low_route)
        low_carrier_route <= reg_wdata[ROUTE_W-1:0];
    end
  end

  // the power-off bit itself stays writable
  always_ff @(posedge mclk) begin
    if (!rst_n)
      modulator_power_off <= RST_POWER_OFF;  // [R12]
    else if (reg_write && hit_periph_dis)
      modulator_power_off <= reg_wdata[POS_MODULATOR_POWER_OFF];  // [R13]
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchronisation

  input_sync_if #(.WIDTH(IN_COUNT)) in_bus ();

  assign in_bus.raw[IN_SOURCE_PIN] = source_pin;
  assign in_bus.raw[IN_HIGH_PIN]   = high_carrier_pin;
  assign in_bus.raw[IN_LOW_PIN]    = low_carrier_pin;
  assign in_bus.raw[IN_FAST_OSC]   = internal_fast_oscillator;
  assign in_bus.raw[IN_REF_CLK]    = reference_clock_output;
  assign in_bus.raw[IN_CAPTURE1]   = capture_unit_one;
  assign in_bus.raw[IN_CAPTURE2]   = capture_unit_two;
  assign in_bus.raw[IN_PWIDTH3]    = pulse_width_unit_three;
  assign in_bus.raw[IN_PWIDTH4]    = pulse_width_unit_four;
  assign in_bus.raw[IN_COMP1]      = comparator_one;
  assign in_bus.raw[IN_COMP2]      = comparator_two;
  assign in_bus.raw[IN_ASYNC_RX]   = async_serial_port_rx;
  assign in_bus.raw[IN_ASYNC_TX]   = async_serial_port_tx;
  assign in_bus.raw[IN_SYNC_DOUT]  = sync_serial_port_dout;

  input_sync #(.WIDTH(IN_COUNT)) u_input_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .port_io (in_bus.sync)
  );

  wire [IN_COUNT-1:0] in_s = in_bus.synced;

  // system clock carrier as mclk/2
  logic sysclk_carrier;

  always_ff @(posedge mclk) begin
    if (!rst_n)
      sysclk_carrier <= 1'b0;
    else
      sysclk_carrier <= !sysclk_carrier;
  end

  ////////////////////////////////////////////////////////////////////////
  // source and carrier selection

  logic selected_source;

  always_comb begin
    unique case (modulator_source_code)  // [R1]
      SRC_PIN:       selected_source = in_s[IN_SOURCE_PIN];
      SRC_SW_BIT:    selected_source = software_data_bit;  // [R9]
      SRC_CAPTURE1:  selected_source = in_s[IN_CAPTURE1];
      SRC_CAPTURE2:  selected_source = in_s[IN_CAPTURE2];
      SRC_PWIDTH3:   selected_source = in_s[IN_PWIDTH3];
      SRC_PWIDTH4:   selected_source = in_s[IN_PWIDTH4];
      SRC_COMP1:     selected_source = in_s[IN_COMP1];
      SRC_COMP2:     selected_source = in_s[IN_COMP2];
      SRC_ASYNC_RX:  selected_source = in_s[IN_ASYNC_RX];
      SRC_ASYNC_TX:  selected_source = in_s[IN_ASYNC_TX];
      SRC_SYNC_DOUT: selected_source = in_s[IN_SYNC_DOUT];
      default:       selected_source = 1'b0;  // reserved codes give zero
    endcase
  end

  // disabled: software bit drives the mixer
  wire modulator_signal = modulator_enable ? selected_source
                                           : software_data_bit;  // [R3] [R4]

  function automatic logic pick_carrier(input logic [CAR_CODE_W-1:0] code,
                                        input logic                  pin);
    logic val;
    val = 1'b0;
    unique case (code)  // [R14]
      CAR_PIN:      val = pin;
      CAR_SYSCLK:   val = sysclk_carrier;
      CAR_FAST_OSC: val = in_s[IN_FAST_OSC];
      CAR_REF_CLK:  val = in_s[IN_REF_CLK];
      CAR_CAPTURE1: val = in_s[IN_CAPTURE1];
      CAR_CAPTURE2: val = in_s[IN_CAPTURE2];
      CAR_PWIDTH3:  val = in_s[IN_PWIDTH3];
      CAR_PWIDTH4:  val = in_s[IN_PWIDTH4];
    endcase
    return val;
  endfunction : pick_carrier

  // disabled: carriers fall back to pins
  wire [CAR_CODE_W-1:0] eff_high_code = modulator_enable ? high_carrier_code
                                                         : CAR_PIN;  // [R2]
  wire [CAR_CODE_W-1:0] eff_low_code  = modulator_enable ? low_carrier_code
                                                         : CAR_PIN;  // [R2]

  wire high_raw  = pick_carrier(eff_high_code, in_s[IN_HIGH_PIN]);
  wire low_raw   = pick_carrier(eff_low_code, in_s[IN_LOW_PIN]);
  wire high_cond = high_raw ^ high_carrier_invert;  // [R8]
  wire low_cond  = low_raw ^ low_carrier_invert;    // [R8]

  ////////////////////////////////////////////////////////////////////////
  // carrier switching with optional synchronisation

  carrier_state_e pass_state;
  carrier_state_e next_pass_state;

  // leaving a synced carrier waits until its pulse is low
  wire leave_high_ok = !high_carrier_sync_enable || !high_cond;  // [R6] [R7]
  wire leave_low_ok  = !low_carrier_sync_enable || !low_cond;    // [R6] [R7]

  always_comb begin
    next_pass_state = pass_state;
    unique case (pass_state)
      PASS_HIGH: if (!modulator_signal && leave_high_ok) begin  // [R16]
        next_pass_state = PASS_LOW;
      end
      PASS_LOW: if (modulator_signal && leave_low_ok) begin  // [R16]
        next_pass_state = PASS_HIGH;
      end
      default: next_pass_state = PASS_LOW;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (hold_defaults)
      pass_state <= PASS_LOW;
    else
      pass_state <= next_pass_state;
  end

  // mixing runs even when disabled
  wire mixed = (next_pass_state == PASS_HIGH) ? high_cond : low_cond;  // [R16]

  // disabled counts low, then polarity
  wire gated     = modulator_enable && mixed;            // [R2] [R5] [R17]
  wire pin_value = (gated ^ output_invert)
                   && !modulator_power_off;              // [R10] [R13]

  // runs on mclk alone; sleep needs nothing [R11]
  always_ff @(posedge mclk) begin
    if (!rst_n)
      modulated_out <= 1'b0;  // [R12]
    else
      modulated_out <= pin_value;
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  wire [DATA_W-1:0] control_a_view = {modulator_enable, 1'b0, modulated_out,
                                      output_invert, 3'h0,
                                      software_data_bit};  // [R15]
  wire [DATA_W-1:0] control_b_view = {2'h0, high_carrier_invert,
                                      high_carrier_sync_enable, 2'h0,
                                      low_carrier_invert,
                                      low_carrier_sync_enable};

  logic [DATA_W-1:0] read_mux;

  always_comb begin
    read_mux = UNMAPPED_READ;
    if (hit_control_a)    read_mux = control_a_view;
    if (hit_control_b)    read_mux = control_b_view;
    if (hit_high_carrier) read_mux = {5'h00, high_carrier_code};
    if (hit_low_carrier)  read_mux = {5'h00, low_carrier_code};
    if (hit_source)       read_mux = {4'h0, modulator_source_code};
    if (hit_low_route)    read_mux = {3'h0, low_carrier_route};
    if (hit_high_route)   read_mux = {3'h0, high_carrier_route};
    if (hit_source_route) read_mux = {3'h0, source_route};
    if (hit_periph_dis)   read_mux = {7'h00, modulator_power_off};
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      reg_rdata <= UNMAPPED_READ;
    else if (reg_read)
      reg_rdata <= read_mux;
    else
      reg_rdata <= UNMAPPED_READ;
  end

endmodule : signal_modulator

//--- inc/modulator_pkg.sv
/*
  data signal modulator constants: offsets, fields, resets, codes.
  assumes an 8-bit register port with a 4-bit word address.
*/
package modulator_pkg;

  // register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets (word index on the register port)
  localparam logic [3:0] OFS_CONTROL_A    = 4'h0;
  localparam logic [3:0] OFS_CONTROL_B    = 4'h1;
  localparam logic [3:0] OFS_HIGH_CARRIER = 4'h2;
  localparam logic [3:0] OFS_LOW_CARRIER  = 4'h3;
  localparam logic [3:0] OFS_SOURCE       = 4'h4;
  localparam logic [3:0] OFS_LOW_ROUTE    = 4'h5;
  localparam logic [3:0] OFS_HIGH_ROUTE   = 4'h6;
  localparam logic [3:0] OFS_SOURCE_ROUTE = 4'h7;
  localparam logic [3:0] OFS_PERIPH_DIS   = 4'h8;

  // control a fields
  localparam int POS_MODULATOR_ENABLE  = 7;
  localparam int POS_OUTPUT_STATUS     = 5;
  localparam int POS_OUTPUT_INVERT     = 4;
  localparam int POS_SOFTWARE_DATA_BIT = 0;

  // control b fields
  localparam int POS_HIGH_CARRIER_INVERT = 5;
  localparam int POS_HIGH_CARRIER_SYNC   = 4;
  localparam int POS_LOW_CARRIER_INVERT  = 1;
  localparam int POS_LOW_CARRIER_SYNC    = 0;

  // peripheral disable field
  localparam int POS_MODULATOR_POWER_OFF = 0;

  // field widths
  localparam int SRC_CODE_W = 4;
  localparam int CAR_CODE_W = 3;
  localparam int ROUTE_W    = 5;

  // reset values
  localparam logic [7:0] RST_CONTROL_A  = 8'h00;
  localparam logic [7:0] RST_CONTROL_B  = 8'h00;
  localparam logic [2:0] RST_CAR_CODE   = 3'h0;
  localparam logic [3:0] RST_SRC_CODE   = 4'h0;
  localparam logic [4:0] RST_ROUTE      = 5'h00;
  localparam logic       RST_POWER_OFF  = 1'b0;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // modulator source codes
  localparam logic [3:0] SRC_PIN       = 4'h0;
  localparam logic [3:0] SRC_SW_BIT    = 4'h1;
  localparam logic [3:0] SRC_CAPTURE1  = 4'h2;
  localparam logic [3:0] SRC_CAPTURE2  = 4'h3;
  localparam logic [3:0] SRC_PWIDTH3   = 4'h4;
  localparam logic [3:0] SRC_PWIDTH4   = 4'h5;
  localparam logic [3:0] SRC_COMP1     = 4'h6;
  localparam logic [3:0] SRC_COMP2     = 4'h7;
  localparam logic [3:0] SRC_ASYNC_RX  = 4'h8;
  localparam logic [3:0] SRC_ASYNC_TX  = 4'h9;
  localparam logic [3:0] SRC_SYNC_DOUT = 4'hA;

  // carrier codes
  localparam logic [2:0] CAR_PIN      = 3'h0;
  localparam logic [2:0] CAR_SYSCLK   = 3'h1;
  localparam logic [2:0] CAR_FAST_OSC = 3'h2;
  localparam logic [2:0] CAR_REF_CLK  = 3'h3;
  localparam logic [2:0] CAR_CAPTURE1 = 3'h4;
  localparam logic [2:0] CAR_CAPTURE2 = 3'h5;
  localparam logic [2:0] CAR_PWIDTH3  = 3'h6;
  localparam logic [2:0] CAR_PWIDTH4  = 3'h7;

  // bit indices of the synchronised input vector
  localparam int IN_SOURCE_PIN = 0;
  localparam int IN_HIGH_PIN   = 1;
  localparam int IN_LOW_PIN    = 2;
  localparam int IN_FAST_OSC   = 3;
  localparam int IN_REF_CLK    = 4;
  localparam int IN_CAPTURE1   = 5;
  localparam int IN_CAPTURE2   = 6;
  localparam int IN_PWIDTH3    = 7;
  localparam int IN_PWIDTH4    = 8;
  localparam int IN_COMP1      = 9;
  localparam int IN_COMP2      = 10;
  localparam int IN_ASYNC_RX   = 11;
  localparam int IN_ASYNC_TX   = 12;
  localparam int IN_SYNC_DOUT  = 13;
  localparam int IN_COUNT      = 14;

  // which carrier is being passed to the output
  typedef enum logic [1:0] {
    PASS_LOW  = 2'b01,
    PASS_HIGH = 2'b10
  } carrier_state_e;

endpackage : modulator_pkg

//--- inc/input_sync_if.sv
/*
  raw and synchronised input vectors of the modulator.
  assumes both ends run on mclk.
*/
`timescale 1ns/1ps

interface input_sync_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;

  modport core (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : input_sync_if

//--- rtl/input_sync.sv
/*
  two-flop synchroniser for async inputs.
  assumes independent bits; no bus coherence.
*/
`timescale 1ns/1ps

module input_sync #(parameter int WIDTH = 1) (
  // clock and reset
  input wire logic   mclk,
  input wire logic   rst_n,
  // vectors
  input_sync_if.sync port_io
);

  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage_one <= '0;
      stage_two <= '0;
    end else begin
      stage_one <= port_io.raw;
      stage_two <= stage_one;
    end
  end

  assign port_io.synced = stage_two;

endmodule : input_sync

//--- tb/signal_modulator_props.sv
/*
  port assertions for the modulator.
  assumes one clock and the modulator_pkg map.
*/
`timescale 1ns/1ps

module signal_modulator_props
  import modulator_pkg::*;
(
  // clock and reset
  input wire logic               mclk,
  input wire logic               rst_n,
  // register port
  input wire logic [ADDR_W-1:0]  reg_addr,
  input wire logic [DATA_W-1:0]  reg_wdata,
  input wire logic               reg_write,
  input wire logic               reg_read,
  input wire logic [DATA_W-1:0]  reg_rdata,
  // outputs
  input wire logic [ROUTE_W-1:0] source_route,
  input wire logic [ROUTE_W-1:0] high_carrier_route,
  input wire logic [ROUTE_W-1:0] low_carrier_route,
  input wire logic               modulated_out
);
  logic en_q;
  logic inv_q;
  logic off_q;
  wire  wr_a   = reg_write && reg_addr == OFS_CONTROL_A;
  wire  wr_off = reg_write && reg_addr == OFS_PERIPH_DIS;

  // shadow of enable, invert and power-off
  always_ff @(posedge mclk) begin
    if (!rst_n || off_q) begin
      en_q  <= 1'b0;
      inv_q <= 1'b0;
    end else if (wr_a) begin
      en_q  <= reg_wdata[POS_MODULATOR_ENABLE];
      inv_q <= reg_wdata[POS_OUTPUT_INVERT];
    end
    if (!rst_n) begin
      off_q <= 1'b0;
    end else if (wr_off) begin
      off_q <= reg_wdata[POS_MODULATOR_POWER_OFF];
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_idle;
    !en_q && !off_q;
  endsequence
  sequence s_off;
    off_q [*2];
  endsequence

  chk_reset_clear: assert property ($rose(rst_n) |-> modulated_out == 1'b0 &&
    reg_rdata == 8'h00 && source_route == 5'h00 && high_carrier_route == 5'h00 &&
    low_carrier_route == 5'h00) else $error("reset not clear");
  chk_read_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("stray read data");
  chk_unmapped_zero: assert property (reg_read && reg_addr > OFS_PERIPH_DIS |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_status_mirror: assert property (reg_read && reg_addr == OFS_CONTROL_A && !off_q
    |=> reg_rdata[POS_OUTPUT_STATUS] == $past(modulated_out)) else $error("status bit wrong");
  chk_idle_pin: assert property (s_idle ##1 s_idle |-> modulated_out == $past(inv_q))
    else $error("idle pin wrong");
  chk_off_pin: assert property (s_off |-> modulated_out == 1'b0)
    else $error("pin high when off");
  chk_off_regs: assert property (s_off ##0 (reg_read && reg_addr != OFS_PERIPH_DIS)
    |=> reg_rdata == 8'h00) else $error("register not default when off");
  chk_route_hold: assert property (!reg_write && !off_q |=> $stable(source_route) &&
    $stable(high_carrier_route) && $stable(low_carrier_route)) else $error("route moved");
endmodule : signal_modulator_props

bind signal_modulator signal_modulator_props u_props (.mclk, .rst_n, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .source_route, .high_carrier_route, .low_carrier_route,
  .modulated_out);

//--- tb/source_model.sv
/*
  far-side pins, clocks and peripheral outputs.
  assumes levels change just after a rising mclk edge.
*/
`timescale 1ns/1ps

module source_model
  import modulator_pkg::*;
#(parameter int OSC_HALF = 3)
(
  // clock
  input  wire logic                mclk,
  // control from the bench
  input  wire logic [IN_COUNT-1:0] level,
  input  wire logic                osc_run,
  // lines to the modulator
  output logic      [IN_COUNT-1:0] line
);
  int   cnt     = 0;
  logic osc     = 1'b0;
  logic ref_div = 1'b0;

  // clocks run as in sleep
  always_ff @(posedge mclk) begin
    if (osc_run && cnt == OSC_HALF - 1) begin
      cnt     <= 0;
      osc     <= ~osc;
      ref_div <= ref_div ^ ~osc;
    end else if (osc_run) begin
      cnt <= cnt + 1;
    end
  end

  always_comb begin
    line = level;
    if (osc_run) begin
      line[IN_FAST_OSC] = osc;
      line[IN_REF_CLK]  = ref_div;
    end
  end
endmodule : source_model

//--- tb/signal_modulator_tb.sv
/*
  self-checking modulator bench.
  assumes the modulator_pkg map.
*/
`timescale 1ns/1ps

module signal_modulator_tb
  import modulator_pkg::*;
;
  logic                mclk      = 1'b0;
  logic                rst_n     = 1'b0;
  logic [ADDR_W-1:0]   reg_addr  = '0;
  logic [DATA_W-1:0]   reg_wdata = '0;
  logic                reg_write = 1'b0;
  logic                reg_read  = 1'b0;
  logic [DATA_W-1:0]   reg_rdata;
  logic [IN_COUNT-1:0] level     = '0;
  logic                osc_run   = 1'b0;
  logic [IN_COUNT-1:0] line;
  logic [ROUTE_W-1:0]  src_rt;
  logic [ROUTE_W-1:0]  hi_rt;
  logic [ROUTE_W-1:0]  lo_rt;
  logic                modulated_out;
  logic [7:0]          mask [1:7] = '{8'h33, 8'h07, 8'h07, 8'h0F, 8'h1F, 8'h1F, 8'h1F};
  logic [16:0]         mix  [6]   = '{17'h10201, 17'h10000, 17'h10240, 17'h10005,
                                      17'h12200, 17'h12001};
  int                  err_count  = 0;
  int                  n_tests    = 0;
  int                  ones;
  int                  idx;

  always #50 mclk = ~mclk;

  source_model u_src (.mclk(mclk), .level(level), .osc_run(osc_run), .line(line));

  signal_modulator u_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .source_pin(line[IN_SOURCE_PIN]), .high_carrier_pin(line[IN_HIGH_PIN]),
    .low_carrier_pin(line[IN_LOW_PIN]), .internal_fast_oscillator(line[IN_FAST_OSC]),
    .reference_clock_output(line[IN_REF_CLK]), .capture_unit_one(line[IN_CAPTURE1]),
    .capture_unit_two(line[IN_CAPTURE2]), .pulse_width_unit_three(line[IN_PWIDTH3]),
    .pulse_width_unit_four(line[IN_PWIDTH4]), .comparator_one(line[IN_COMP1]),
    .comparator_two(line[IN_COMP2]), .async_serial_port_rx(line[IN_ASYNC_RX]),
    .async_serial_port_tx(line[IN_ASYNC_TX]), .sync_serial_port_dout(line[IN_SYNC_DOUT]),
    .source_route(src_rt), .high_carrier_route(hi_rt), .low_carrier_route(lo_rt),
    .modulated_out(modulated_out));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask : check1

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    check8(reg_rdata, exp);
  endtask : rd

  task automatic setlv(input int i, input logic v);
    @(posedge mclk);
    level[i] <= v;
    settle(3);
  endtask : setlv

  task automatic all_default;
    for (int a = 0; a < 13; a++) rd(a[3:0], 8'h00);
    check8({3'h0, src_rt | hi_rt | lo_rt}, 8'h00);
  endtask : all_default

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #5_000_000;
    err_count++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    all_default();
    for (int a = 1; a < 8; a++) begin
      wr(a[3:0], 8'hFF);
      rd(a[3:0], mask[a]);
    end
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00);
    check8({3'h0, src_rt & hi_rt & lo_rt}, 8'h1F);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    all_default();
    // disabled: pin shows polarity
    @(posedge mclk);
    level <= '1;
    level[IN_LOW_PIN] <= 1'b0;
    wr(OFS_SOURCE, 8'(SRC_CAPTURE1));
    wr(OFS_CONTROL_A, 8'h11);
    settle(2);
    check1(modulated_out, 1'b1);
    rd(OFS_CONTROL_A, 8'h31);
    wr(OFS_CONTROL_A, 8'h01);
    settle(2);
    check1(modulated_out, 1'b0);
    rd(OFS_SOURCE, 8'(SRC_CAPTURE1));
    wr(OFS_CONTROL_A, 8'h80);
    settle(2);
    check1(modulated_out, 1'b1);
    // every source code
    for (int c = 0; c < 16; c++) begin
      idx = (c == 0) ? IN_SOURCE_PIN : IN_CAPTURE1 + c - 2;
      wr(OFS_SOURCE, 8'(c));
      settle(2);
      check1(modulated_out, c != 1 && c < 11);
      if (c != 1 && c < 11) begin
        setlv(idx, 1'b0);
        check1(modulated_out, 1'b0);
        setlv(idx, 1'b1);
      end
    end
    // software bit and inversions
    wr(OFS_SOURCE, 8'(SRC_SW_BIT));
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CONTROL_A, mix[i][16:9]);
      wr(OFS_CONTROL_B, mix[i][8:1]);
      settle(2);
      check1(modulated_out, mix[i][0]);
    end
    // every carrier code on both carriers
    wr(OFS_CONTROL_B, 8'h00);
    level <= '0;
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CONTROL_A, 8'h80 | 8'(s));
      for (int c = 0; c < 8; c++) begin
        idx = (c == 0) ? (s == 1 ? IN_HIGH_PIN : IN_LOW_PIN) : c + 1;
        wr(s == 1 ? OFS_HIGH_CARRIER : OFS_LOW_CARRIER, 8'(c));
        osc_run <= (c > 0 && c < 4);
        if (c > 0 && c < 4) begin
          settle(4);
          ones = 0;
          repeat (12) begin
            settle(1);
            ones += int'(modulated_out === 1'b1);
          end
          check8(8'(ones), 8'h06);
        end else begin
          setlv(idx, 1'b1);
          check1(modulated_out, 1'b1);
          setlv(idx, 1'b0);
          check1(modulated_out, 1'b0);
        end
      end
      wr(s == 1 ? OFS_HIGH_CARRIER : OFS_LOW_CARRIER, 8'h00);
    end
    // carrier sync
    osc_run <= 1'b0;
    wr(OFS_CONTROL_B, 8'h10);
    setlv(IN_HIGH_PIN, 1'b1);
    wr(OFS_CONTROL_A, 8'h80);
    settle(4);
    check1(modulated_out, 1'b1);
    setlv(IN_HIGH_PIN, 1'b0);
    check1(modulated_out, 1'b0);
    setlv(IN_HIGH_PIN, 1'b1);
    check1(modulated_out, 1'b0);
    setlv(IN_LOW_PIN, 1'b1);
    setlv(IN_HIGH_PIN, 1'b0);
    wr(OFS_CONTROL_A, 8'h81);
    settle(2);
    check1(modulated_out, 1'b0);
    wr(OFS_CONTROL_B, 8'h01);
    wr(OFS_CONTROL_A, 8'h80);
    wr(OFS_CONTROL_A, 8'h81);
    settle(4);
    check1(modulated_out, 1'b1);
    setlv(IN_LOW_PIN, 1'b0);
    setlv(IN_LOW_PIN, 1'b1);
    check1(modulated_out, 1'b0);
    // power-off
    wr(OFS_CONTROL_A, 8'h91);
    wr(OFS_PERIPH_DIS, 8'h01);
    settle(3);
    check1(modulated_out, 1'b0);
    wr(OFS_CONTROL_A, 8'h80);
    rd(OFS_CONTROL_A, 8'h00);
    rd(OFS_PERIPH_DIS, 8'h01);
    wr(OFS_PERIPH_DIS, 8'h00);
    rd(OFS_CONTROL_B, 8'h00);
    rd(OFS_CONTROL_A, 8'h00);
    test_done();
  end
endmodule : signal_modulator_tb
